/* design/lcd_port_pkg.sv */
// Constants shared by the character display host port.
// Assumes a 100 MHz core clock.
`default_nettype none
package lcd_port_pkg;
  localparam int CLK_PERIOD_NS = 10;
  localparam int EXEC_TIME_NS = 18500;
  localparam int EXEC_CYCLES = (EXEC_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_W = 12;
  // Instruction field positions
  localparam int BIT_TEXT_ADDR = 7;
  localparam int BIT_GLYPH_ADDR = 6;
  localparam int FS_WIDTH_BIT = 4;
  localparam int FS_LINES_BIT = 3;
  localparam int FS_FONT_BIT = 2;
  localparam int SHIFT_SC_BIT = 3;
  localparam int SHIFT_RL_BIT = 2;
  localparam int ENTRY_DIR_BIT = 1;
  localparam logic [2:0] FUNC_SET_CODE = 3'h1;
  localparam logic [3:0] SHIFT_CODE = 4'h1;
  localparam logic [5:0] ENTRY_CODE = 6'h01;
  // Text RAM map
  localparam logic [6:0] TEXT_FIRST = 7'h00;
  localparam logic [6:0] ONE_ROW_LAST = 7'h4F;
  localparam logic [6:0] ROW0_LAST = 7'h27;
  localparam logic [6:0] ROW1_FIRST = 7'h40;
  localparam logic [6:0] ROW1_LAST = 7'h67;
  // Drive duty divisors
  localparam logic [4:0] DUTY_SHORT = 5'h08;
  localparam logic [4:0] DUTY_TALL = 5'h0B;
  localparam logic [4:0] DUTY_TWO_ROW = 5'h10;
  // Reset values
  localparam logic RESET_BUS_WIDTH = 1'b1;
  localparam logic RESET_TWO_ROW = 1'b0;
  localparam logic RESET_FONT_TALL = 1'b0;
  localparam logic RESET_STEP_UP = 1'b1;
  // Strap codes, bit 1 is the first strap
  localparam logic [1:0] STRAP_PARALLEL = 2'h0;
  localparam logic [1:0] STRAP_I2C = 2'h1;
  localparam logic [1:0] STRAP_SERIAL = 2'h2;
  typedef enum logic [1:0] {MODE_PARALLEL, MODE_I2C, MODE_SERIAL, MODE_NONE} host_mode_e;
endpackage : lcd_port_pkg
`default_nettype wire

/* design/sync_2ff.sv */
// Two flip-flop synchroniser for a vector of levels.
// Assumes each bit is a level that stays put for several clocks.
`default_nettype none
module sync_2ff #(
  parameter int WIDTH = 1
) (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  logic [WIDTH-1:0] stage;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      stage <= '0;
      sync_o <= '0;
    end else begin
      stage <= async_i;
      sync_o <= stage;
    end
  end
endmodule : sync_2ff
`default_nettype wire

/* design/serial_rx.sv */
// Four-line serial receiver on the host's serial clock.
// Assumes the clock idles high and data is stable across the rising edge.
`default_nettype none
module serial_rx (
  input wire logic serial_clk_i,
  input wire logic rstn_i,
  input wire logic chip_select_n_i,
  input wire logic serial_in_line_i,
  input wire logic reg_select_i,
  output logic [7:0] byte_o,
  output logic rs_o,
  output logic toggle_o
);
  logic [2:0] bit_count;
  logic [6:0] shift;
  logic frame_rst;
  assign frame_rst = !rstn_i || chip_select_n_i;
  // Bit position restarts whenever chip select is released
  always_ff @(posedge serial_clk_i or posedge frame_rst) begin
    if (frame_rst) begin
      bit_count <= 3'h0;
      shift <= 7'h00;
    end else begin
      bit_count <= bit_count + 3'h1;
      shift <= {shift[5:0], serial_in_line_i};
    end
  end
  // Byte and toggle survive chip select so the core never sees a false event
  always_ff @(posedge serial_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      byte_o <= 8'h00;
      rs_o <= 1'b0;
      toggle_o <= 1'b0;
    end else if (!chip_select_n_i && bit_count == 3'h7) begin
      byte_o <= {shift, serial_in_line_i};
      rs_o <= reg_select_i;
      toggle_o <= !toggle_o;
    end
  end
  eighth_bit_a: assert property (@(posedge serial_clk_i) disable iff (frame_rst)
    bit_count == 3'h7 |=> $changed(toggle_o) && byte_o[0] == $past(serial_in_line_i))
    else $error("byte not delivered after eighth bit");
endmodule : serial_rx
`default_nettype wire

/* design/lcd_host_port.sv */
// Host instruction and data port of a character display controller.
// Assumes serial_clk_i is wired to bus line 6 and the host keeps its timing.
// Functional notes
// - Font bit picks 5x8 or 5x11 in one row; duty 1/8, 1/11, 1/16.
// - Glyph address-set loads six bits into address counter and selects glyph RAM.
// - Text address-set loads seven bits into address counter and selects text RAM.
// - One-row text addresses run 00H to 4FH contiguously.
// - Two-row text rows are 00H-27H and 40H-67H.
// - Status read gives busy on bit 7, counter below; parallel only.
// - Data write stores the byte into the RAM last selected.
// - Every data write steps the address counter by one per direction.
// - Data read returns selected RAM byte, parallel only; first may be invalid.
// - Repeated reads after a write: first byte stale, later ones correct.
// - Cursor shift with text RAM selected reloads the output register.
// - Every data read steps the address counter by one per direction.
// - After a write, a read returns the old output register content.
// - Each write transfer lands in a command or data latch by register select.
// - Four-bit mode uses lines 4-7, upper nibble first.
// - Four-bit mode raises busy only after the second nibble.
// - Eight-bit mode moves a byte per strobe on all lines.
// - Two straps select parallel, I2C or four-line serial; I2C mode has no receiver and takes no transfers.
// - Serial mode: line 5 select, 7 data, 6 clock, register select.
// - Direction bit 1 increments, 0 decrements the address counter.
// - Line-count bit picks one or two rows, address map and duty.
`default_nettype none
module lcd_host_port (
  input wire logic clk_i,
  input wire logic rstn_i,
  input wire logic serial_clk_i,
  input wire logic [1:0] host_select_straps_i,
  input wire logic strobe_i,
  input wire logic reg_select_i,
  input wire logic read_not_write_i,
  input wire logic [7:0] bus_line_i,
  output logic [7:0] bus_line_o,
  output logic [7:0] bus_line_oe_o,
  output logic busy_indicator_o,
  output logic [6:0] address_counter_o,
  output logic bus_width_bit_o,
  output logic two_row_o,
  output logic font_tall_o,
  output logic step_up_o,
  output logic [4:0] duty_divisor_o,
  output lcd_port_pkg::host_mode_e host_mode_o
);
  import lcd_port_pkg::*;

  function automatic host_mode_e decode_mode(input logic [1:0] straps);
    unique case (straps)
      STRAP_PARALLEL: decode_mode = MODE_PARALLEL;
      STRAP_I2C: decode_mode = MODE_I2C;
      STRAP_SERIAL: decode_mode = MODE_SERIAL;
      default: decode_mode = MODE_NONE;
    endcase
  endfunction : decode_mode

  // Next text or glyph address, one step in the given direction
  function automatic logic [6:0] step_addr(input logic [6:0] a, input logic up,
                                           input logic glyph, input logic rows2);
    logic [6:0] r;
    r = up ? a + 7'h01 : a - 7'h01;
    if (glyph) begin
      r = {1'b0, r[5:0]};
    end else if (!rows2) begin
      if (up && a == ONE_ROW_LAST) r = TEXT_FIRST;
      if (!up && a == TEXT_FIRST) r = ONE_ROW_LAST;
    end else begin
      if (up && a == ROW0_LAST) r = ROW1_FIRST;
      if (up && a == ROW1_LAST) r = TEXT_FIRST;
      if (!up && a == ROW1_FIRST) r = ROW0_LAST;
      if (!up && a == TEXT_FIRST) r = ROW1_LAST;
    end
    step_addr = r;
  endfunction : step_addr

  logic [1:0] rst_pipe;
  logic rst_n;
  always_ff @(posedge clk_i or negedge rstn_i) begin
    if (!rstn_i) rst_pipe <= 2'h0;
    else rst_pipe <= {rst_pipe[0], 1'b1};
  end
  assign rst_n = rst_pipe[1];

  logic [7:0] ser_byte;
  logic ser_rs;
  logic ser_toggle;
  serial_rx link_rx (
    .serial_clk_i(serial_clk_i),
    .rstn_i(rst_n),
    .chip_select_n_i(bus_line_i[5]),
    .serial_in_line_i(bus_line_i[7]),
    .reg_select_i(reg_select_i),
    .byte_o(ser_byte),
    .rs_o(ser_rs),
    .toggle_o(ser_toggle)
  );

  logic [13:0] sync_out;
  sync_2ff #(.WIDTH(14)) pin_sync (
    .clk_i(clk_i),
    .rstn_i(rst_n),
    .async_i({ser_toggle, host_select_straps_i, strobe_i, reg_select_i, read_not_write_i, bus_line_i}),
    .sync_o(sync_out)
  );
  logic tog_s;
  logic [1:0] straps_s;
  logic strobe_s;
  logic rs_s;
  logic rw_s;
  logic [7:0] bus_s;
  assign {tog_s, straps_s, strobe_s, rs_s, rw_s, bus_s} = sync_out;

  host_mode_e mode;
  assign mode = decode_mode(straps_s);
  assign host_mode_o = mode;

  logic bus_width;
  logic two_row;
  logic font_tall;
  logic step_up;
  logic strobe_prev;
  logic tog_prev;
  logic phase;
  logic [3:0] hi_nib;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      strobe_prev <= 1'b0;
      tog_prev <= 1'b0;
    end else begin
      strobe_prev <= strobe_s;
      tog_prev <= tog_s;
    end
  end

  logic strobe_fall;
  assign strobe_fall = strobe_prev && !strobe_s && mode == MODE_PARALLEL;

  // Nibble phase: 0 expects the upper nibble, 1 the lower
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      phase <= 1'b0;
      hi_nib <= 4'h0;
    end else if (bus_width || mode != MODE_PARALLEL) begin
      phase <= 1'b0;
    end else if (strobe_fall) begin
      phase <= !phase;
      if (!phase) hi_nib <= bus_s[7:4];
    end
  end

  logic par_take;
  logic ser_take;
  logic take;
  logic [7:0] in_byte;
  logic in_rs;
  logic in_rw;
  assign par_take = strobe_fall && (bus_width || phase);
  assign ser_take = mode == MODE_SERIAL && (tog_s != tog_prev);
  assign take = par_take || ser_take;
  assign in_byte = ser_take ? ser_byte : (bus_width ? bus_s : {hi_nib, bus_s[7:4]});
  assign in_rs = ser_take ? ser_rs : rs_s;
  assign in_rw = ser_take ? 1'b0 : rw_s;

  logic [7:0] command_latch;
  logic [7:0] data_latch;
  logic cmd_go;
  logic wr_go;
  logic rd_go;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      command_latch <= 8'h00;
      data_latch <= 8'h00;
      cmd_go <= 1'b0;
      wr_go <= 1'b0;
      rd_go <= 1'b0;
    end else begin
      cmd_go <= take && !in_rs && !in_rw;
      wr_go <= take && in_rs && !in_rw;
      rd_go <= take && in_rs && in_rw;
      if (take && !in_rs && !in_rw) command_latch <= in_byte;
      if (take && in_rs && !in_rw) data_latch <= in_byte;
    end
  end

  // Busy runs for one execution time; a status read does not start it
  logic [BUSY_W-1:0] busy_count;
  logic busy;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) busy_count <= '0;
    else if (take && (in_rs || !in_rw)) busy_count <= BUSY_W'(EXEC_CYCLES);
    else if (busy_count != '0) busy_count <= busy_count - 1'b1;
  end
  assign busy = busy_count != '0;

  logic is_func;
  logic is_entry;
  logic is_shift;
  assign is_func = command_latch[7:5] == FUNC_SET_CODE;
  assign is_entry = command_latch[7:2] == ENTRY_CODE;
  assign is_shift = command_latch[7:4] == SHIFT_CODE && !command_latch[SHIFT_SC_BIT];

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      bus_width <= RESET_BUS_WIDTH;
      two_row <= RESET_TWO_ROW;
      font_tall <= RESET_FONT_TALL;
      step_up <= RESET_STEP_UP;
    end else if (cmd_go) begin
      if (is_func) begin
        bus_width <= command_latch[FS_WIDTH_BIT];
        two_row <= command_latch[FS_LINES_BIT];
        font_tall <= command_latch[FS_FONT_BIT];
      end
      if (is_entry) step_up <= command_latch[ENTRY_DIR_BIT];
    end
  end

  logic [6:0] ac;
  logic glyph_sel;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      ac <= 7'h00;
      glyph_sel <= 1'b0;
    end else if (cmd_go) begin
      if (command_latch[BIT_TEXT_ADDR]) begin
        ac <= command_latch[6:0];
        glyph_sel <= 1'b0;
      end else if (command_latch[BIT_GLYPH_ADDR]) begin
        ac <= {1'b0, command_latch[5:0]};
        glyph_sel <= 1'b1;
      end else if (is_shift) begin
        ac <= step_addr(ac, command_latch[SHIFT_RL_BIT], glyph_sel, two_row);
      end
    end else if (wr_go || rd_go) begin
      ac <= step_addr(ac, step_up, glyph_sel, two_row);
    end
  end

  logic [7:0] text_ram [128];
  logic [7:0] glyph_ram [64];
  always_ff @(posedge clk_i) begin
    if (wr_go && glyph_sel) glyph_ram[ac[5:0]] <= data_latch;
    if (wr_go && !glyph_sel) text_ram[ac] <= data_latch;
  end

  // Output register refills only after address set, text cursor shift or read
  logic reload;
  logic [7:0] out_reg;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      reload <= 1'b0;
      out_reg <= 8'h00;
    end else begin
      reload <= rd_go || (cmd_go && (command_latch[7:6] != 2'h0 || (is_shift && !glyph_sel)));
      if (reload) out_reg <= glyph_sel ? glyph_ram[ac[5:0]] : text_ram[ac];
    end
  end

  // Read drive, parallel only; 4-bit reads give the upper nibble first
  logic [7:0] view;
  logic drive;
  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      drive <= 1'b0;
      bus_line_o <= 8'h00;
    end else begin
      drive <= mode == MODE_PARALLEL && strobe_s && rw_s;
      if (bus_width) bus_line_o <= view;
      else bus_line_o <= {phase ? view[3:0] : view[7:4], 4'h0};
    end
  end
  assign view = rs_s ? out_reg : {busy, ac};
  assign bus_line_oe_o = drive ? (bus_width ? 8'hFF : 8'hF0) : 8'h00;

  assign busy_indicator_o = busy;
  assign address_counter_o = ac;
  assign bus_width_bit_o = bus_width;
  assign two_row_o = two_row;
  assign font_tall_o = font_tall && !two_row;
  assign step_up_o = step_up;
  assign duty_divisor_o = two_row ? DUTY_TWO_ROW : (font_tall ? DUTY_TALL : DUTY_SHORT);

  sequence byte_taken_s;
    take && (in_rs || !in_rw);
  endsequence
  sequence busy_stays_s;
    busy [*8];
  endsequence

  busy_after_take_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    byte_taken_s |=> busy_stays_s)
    else $error("busy not raised after byte");
  first_nibble_quiet_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    strobe_fall && !bus_width && !phase |-> !take ##1 phase)
    else $error("first nibble executed");
  text_addr_set_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    cmd_go && command_latch[7] |=> ac == $past(command_latch[6:0]) && !glyph_sel)
    else $error("text address not loaded");
  glyph_addr_set_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    cmd_go && command_latch[7:6] == 2'h1 |=> ac == {1'b0, $past(command_latch[5:0])} && glyph_sel)
    else $error("glyph address not loaded");
  write_step_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_go && step_up && !glyph_sel && !two_row && ac < ONE_ROW_LAST |=> ac == $past(ac) + 7'h01)
    else $error("address not stepped after write");
  read_step_down_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    rd_go && !step_up && glyph_sel && ac[5:0] != 6'h00 |=> ac == $past(ac) - 7'h01)
    else $error("address not stepped after read");
  one_row_wrap_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (wr_go || rd_go) && step_up && !glyph_sel && !two_row && ac == ONE_ROW_LAST |=> ac == TEXT_FIRST)
    else $error("one-row wrap wrong");
  row_jump_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    (wr_go || rd_go) && step_up && !glyph_sel && two_row && ac == ROW0_LAST |=> ac == ROW1_FIRST)
    else $error("row jump wrong");
  duty_map_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    duty_divisor_o == (two_row ? 5'h10 : (font_tall ? 5'h0B : 5'h08)))
    else $error("duty does not match mode");
  write_no_reload_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    wr_go && !reload |=> ##1 $stable(out_reg))
    else $error("write reloaded output register");
  parallel_drive_a: assert property (@(posedge clk_i) disable iff (!rst_n)
    bus_line_oe_o != 8'h00 |-> $past(mode) == MODE_PARALLEL && $past(strobe_s))
    else $error("bus driven outside parallel read");
endmodule : lcd_host_port
`default_nettype wire

/* verification/host_model.sv */
// Host processor model: parallel strobe cycles, busy polling and four-line serial frames.
// Assumes a 100 MHz design clock and design pins sampled through two flops.
`default_nettype none
module host_model (
  input wire logic clk_i,
  input wire logic [7:0] dut_bus_i,
  input wire logic [7:0] dut_oe_i,
  output logic strobe_o,
  output logic reg_select_o,
  output logic read_not_write_o,
  output logic [7:0] bus_line_o,
  output logic serial_clk_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] drive = 8'hFF;
  logic host_en = 1'b1;
  logic [7:0] last_oe;
  initial begin
    strobe_o = 1'b0;
    reg_select_o = 1'b0;
    read_not_write_o = 1'b0;
    serial_clk_o = 1'b1;
  end
  // Released lines show the inverse of the current drive value
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      bus_line_o[i] = dut_oe_i[i] ? dut_bus_i[i] : (host_en ? drive[i] : !drive[i]);
    end
  end
  task automatic cycle(input logic rs, input logic rw, input logic [7:0] val, output logic [7:0] rd);
    @(posedge clk_i);
    #1;
    reg_select_o = rs;
    read_not_write_o = rw;
    drive = val;
    host_en = !rw;
    repeat (4) @(posedge clk_i);
    #1;
    strobe_o = 1'b1;
    repeat (7) @(posedge clk_i);
    #1;
    rd = bus_line_o;
    last_oe = dut_oe_i;
    strobe_o = 1'b0;
    repeat (5) @(posedge clk_i);
    #1;
    host_en = 1'b1;
  endtask : cycle
  task automatic xfer(input logic rs, input logic rw, input logic [7:0] val, input logic four,
                      output logic [7:0] rd);
    logic [7:0] hi;
    if (four) begin
      cycle(rs, rw, {val[7:4], 4'h0}, hi);
      cycle(rs, rw, {val[3:0], 4'h0}, rd);
      rd = {hi[7:4], rd[7:4]};
    end else begin
      cycle(rs, rw, val, rd);
    end
  endtask : xfer
  task automatic wait_ready(input logic four, output logic ok);
    logic [7:0] st;
    ok = 1'b0;
    for (int n = 0; n < 200 && !ok; n++) begin
      xfer(1'b0, 1'b1, 8'h00, four, st);
      ok = !st[7];
    end
    repeat (2) @(posedge clk_i);
  endtask : wait_ready
  // Serial frame: chip select on line 5, clock on line 6, data on line 7
  task automatic frame(input logic rs, input logic [7:0] val, input int bits);
    #20.3;
    reg_select_o = rs;
    drive[5] = 1'b0;
    for (int i = 0; i < bits; i++) begin
      serial_clk_o = 1'b0;
      drive[6] = 1'b0;
      drive[7] = val[7 - i];
      #3;
      serial_clk_o = 1'b1;
      drive[6] = 1'b1;
      #3;
    end
    drive[5] = 1'b1;
  endtask : frame
endmodule : host_model
`default_nettype wire

/* verification/tb_char_lcd_host_instruction_port.sv */
// Self-checking bench for the character display host port.
// Assumes the host model drives every pin except straps and reset, which the bench drives, and each executed byte holds busy for EXEC_CYCLES clocks.
`default_nettype none
`define CHK(got, exp) begin \
  checks++; \
  if ((got) !== (exp)) begin \
    fail_count++; \
    $display("unexpected at %0t: got %h expected %h", $time, (got), (exp)); \
  end \
end
module tb_char_lcd_host_instruction_port;
  import lcd_port_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [1:0] straps = STRAP_PARALLEL;
  logic strobe, rs, rw, sclk, ok;
  logic [7:0] bus, dut_bus, dut_oe, rd;
  logic busy, bw, two_row, font, step_up;
  logic [6:0] ac;
  logic [4:0] duty;
  host_mode_e mode;
  int fail_count = 0;
  int checks = 0;
  // Function set code, then {two_row, font, duty}
  logic [15:0] fs [4] = '{16'h342B, 16'h3850, 16'h3C50, 16'h3008};
  // Function set, entry mode, address set, counter after one write
  logic [31:0] at [5] = '{32'h3806A740, 32'h3804C027, 32'h3006CF00, 32'h3004804F, 32'h30067F00};
  logic [7:0] dat [3] = '{8'h11, 8'h22, 8'h33};
  always #5 clk = !clk;
  lcd_host_port DUT (
    .clk_i(clk), .rstn_i(rstn), .serial_clk_i(sclk), .host_select_straps_i(straps),
    .strobe_i(strobe), .reg_select_i(rs), .read_not_write_i(rw), .bus_line_i(bus),
    .bus_line_o(dut_bus), .bus_line_oe_o(dut_oe), .busy_indicator_o(busy), .address_counter_o(ac),
    .bus_width_bit_o(bw), .two_row_o(two_row), .font_tall_o(font), .step_up_o(step_up),
    .duty_divisor_o(duty), .host_mode_o(mode)
  );
  host_model u_host (
    .clk_i(clk), .dut_bus_i(dut_bus), .dut_oe_i(dut_oe), .strobe_o(strobe), .reg_select_o(rs),
    .read_not_write_o(rw), .bus_line_o(bus), .serial_clk_o(sclk)
  );
  task automatic print_verdict;
    $display("checks %0d fail_count %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : print_verdict
  task automatic do_reset(input logic [1:0] s);
    @(posedge clk);
    #1;
    rstn = 1'b0;
    straps = s;
    repeat (3) @(posedge clk);
    #1;
    rstn = 1'b1;
    repeat (10) @(posedge clk);
  endtask : do_reset
  // Executed transfer: busy must be up, then poll until it drops
  task automatic op(input logic r, input logic w, input logic [7:0] v, input logic four);
    u_host.xfer(r, w, v, four, rd);
    repeat (2) @(posedge clk);
    `CHK(busy, 1'b1)
    u_host.wait_ready(four, ok);
    `CHK(ok, 1'b1)
    if (!ok) print_verdict();
  endtask : op
  task automatic status(input logic [6:0] exp_ac);
    u_host.xfer(1'b0, 1'b1, 8'h00, 1'b0, rd);
    `CHK(rd, {1'b0, exp_ac})
  endtask : status
  initial begin
    repeat (99000) @(posedge clk);
    fail_count++;
    $display("unexpected at %0t: run limit reached", $time);
    print_verdict();
  end
  initial begin
    do_reset(STRAP_PARALLEL);
    `CHK({bw, two_row, font, step_up, duty}, {4'h9, DUTY_SHORT})
    `CHK(mode, MODE_PARALLEL)
    `CHK({busy, ac}, 8'h00)
    for (int i = 0; i < 4; i++) begin
      op(1'b0, 1'b0, fs[i][15:8], 1'b0);
      `CHK({two_row, font, duty}, fs[i][6:0])
    end
    for (int i = 0; i < 5; i++) begin
      op(1'b0, 1'b0, at[i][31:24], 1'b0);
      op(1'b0, 1'b0, at[i][23:16], 1'b0);
      `CHK(step_up, at[i][17])
      op(1'b0, 1'b0, at[i][15:8], 1'b0);
      status(at[i][15] ? at[i][14:8] : {1'b0, at[i][13:8]});
      op(1'b1, 1'b0, 8'hC3, 1'b0);
      status(at[i][6:0]);
    end
    op(1'b0, 1'b0, 8'h85, 1'b0);
    foreach (dat[k]) op(1'b1, 1'b0, dat[k], 1'b0);
    op(1'b0, 1'b0, 8'h85, 1'b0);
    foreach (dat[k]) begin
      op(1'b1, 1'b1, 8'h00, 1'b0);
      `CHK(rd, dat[k])
      `CHK(u_host.last_oe, 8'hFF)
    end
    status(7'h08);
    op(1'b0, 1'b0, 8'h10, 1'b0);
    op(1'b1, 1'b1, 8'h00, 1'b0);
    `CHK(rd, 8'h33)
    op(1'b0, 1'b0, 8'h85, 1'b0);
    op(1'b1, 1'b0, 8'h66, 1'b0);
    op(1'b1, 1'b1, 8'h00, 1'b0);
    `CHK(rd, 8'h11)
    u_host.cycle(1'b0, 1'b0, 8'h20, rd);
    u_host.wait_ready(1'b1, ok);
    `CHK(ok, 1'b1)
    if (!ok) print_verdict();
    `CHK(bw, 1'b0)
    u_host.cycle(1'b0, 1'b0, 8'h90, rd);
    repeat (3) @(posedge clk);
    `CHK(busy, 1'b0)
    u_host.cycle(1'b0, 1'b0, 8'h00, rd);
    repeat (2) @(posedge clk);
    `CHK(busy, 1'b1)
    u_host.wait_ready(1'b1, ok);
    `CHK(ok, 1'b1)
    if (!ok) print_verdict();
    op(1'b1, 1'b0, 8'h5A, 1'b1);
    op(1'b0, 1'b0, 8'h90, 1'b1);
    op(1'b1, 1'b1, 8'h00, 1'b1);
    `CHK(rd, 8'h5A)
    `CHK(u_host.last_oe, 8'hF0)
    u_host.xfer(1'b0, 1'b0, 8'h30, 1'b1, rd);
    u_host.wait_ready(1'b0, ok);
    `CHK(ok, 1'b1)
    if (!ok) print_verdict();
    `CHK(bw, 1'b1)
    u_host.drive = 8'hFF;
    do_reset(STRAP_SERIAL);
    `CHK(mode, MODE_SERIAL)
    u_host.frame(1'b0, 8'hE0, 3);
    u_host.frame(1'b0, 8'h38, 8);
    repeat (1900) @(posedge clk);
    `CHK({two_row, bw}, 2'b11)
    u_host.frame(1'b0, 8'h83, 8);
    repeat (1900) @(posedge clk);
    u_host.frame(1'b1, 8'h77, 8);
    repeat (1900) @(posedge clk);
    `CHK(ac, 7'h04)
    do_reset(STRAP_I2C);
    `CHK(mode, MODE_I2C)
    u_host.cycle(1'b0, 1'b0, 8'h38, rd);
    repeat (3) @(posedge clk);
    `CHK({busy, two_row}, 2'b00)
    print_verdict();
  end
endmodule : tb_char_lcd_host_instruction_port
`default_nettype wire
